// file: mbac_pkg.sv
// Package for the mode based access checker: modes, operations, address map,
// register offsets and the packed carriers shared by the checker ports.
// Assumes one 8-bit CPU core, an external register file and 18-bit physical addresses.
package mbac_pkg;

    // CPU modes
    typedef enum logic [2:0] {
        MBAC_BOOT = 3'h0,
        MBAC_TEST = 3'h1,
        MBAC_CLOS = 3'h2,
        MBAC_SYS  = 3'h3,
        MBAC_USER = 3'h4
    } mbac_mode_t;

    // Memory operations
    typedef enum logic [1:0] {
        MBAC_OP_READ  = 2'h0,
        MBAC_OP_WRITE = 2'h1,
        MBAC_OP_EXEC  = 2'h2
    } mbac_op_t;

    // Memory regions after decoding
    typedef enum logic [3:0] {
        MBAC_RG_NONE    = 4'h0,
        MBAC_RG_ROM_TST = 4'h1,
        MBAC_RG_ROM_APP = 4'h2,
        MBAC_RG_ROM_ACM = 4'h3,
        MBAC_RG_EE_OS   = 4'h4,
        MBAC_RG_EE_APP  = 4'h5,
        MBAC_RG_RAM_OS  = 4'h6,
        MBAC_RG_RAM_APP = 4'h7,
        MBAC_RG_CP_RAM  = 4'h8,
        MBAC_RG_SEC_ROW = 4'h9
    } mbac_region_t;

    // Register groups
    typedef enum logic [2:0] {
        MBAC_GR_NONE = 3'h0,
        MBAC_GR_CPU  = 3'h1,
        MBAC_GR_SEG  = 3'h2,
        MBAC_GR_SYSM = 3'h3,
        MBAC_GR_FW   = 3'h4,
        MBAC_GR_OS   = 3'h5,
        MBAC_GR_TST  = 3'h6,
        MBAC_GR_HW   = 3'h7
    } mbac_group_t;

    // Physical memory map, inclusive bounds
    localparam logic [17:0] ROM_TST_LO = 18'h00000;
    localparam logic [17:0] ROM_TST_HI = 18'h07fff;
    localparam logic [17:0] ROM_APP_LO = 18'h08000;
    localparam logic [17:0] ROM_APP_HI = 18'h1ffff;
    localparam logic [17:0] ROM_ACM_LO = 18'h1ffc0;
    localparam logic [17:0] EE_OS_LO = 18'h20000;
    localparam logic [17:0] EE_OS_HI = 18'h21fff;
    localparam logic [17:0] EE_APP_LO = 18'h22000;
    localparam logic [17:0] EE_APP_HI = 18'h3bfff;
    localparam logic [17:0] RAM_OS_LO = 18'h3c000;
    localparam logic [17:0] RAM_OS_HI = 18'h3c3ff;
    localparam logic [17:0] RAM_APP_LO = 18'h3c400;
    localparam logic [17:0] RAM_APP_HI = 18'h3dfff;
    localparam logic [17:0] CP_RAM_LO = 18'h3e000;
    localparam logic [17:0] CP_RAM_HI = 18'h3e7ff;
    localparam logic [17:0] SEC_ROW_LO = 18'h3f000;
    localparam logic [17:0] SEC_ROW_HI = 18'h3f0ff;

    // Register group bounds, inclusive
    localparam logic [7:0] GR_CPU_LO = 8'h80;
    localparam logic [7:0] GR_SEG_LO = 8'h90;
    localparam logic [7:0] GR_SYSM_LO = 8'h98;
    localparam logic [7:0] GR_FW_LO = 8'ha0;
    localparam logic [7:0] GR_OS_LO = 8'ha8;
    localparam logic [7:0] GR_TST_LO = 8'hb0;
    localparam logic [7:0] GR_HW_LO = 8'hc0;

    // Single registers with special treatment
    localparam logic [7:0] ADDR_STATUS_HI = 8'h98;
    localparam logic [7:0] ADDR_SYSPTR0 = 8'h99;
    localparam logic [7:0] ADDR_SYSPTR1 = 8'h9a;
    localparam logic [7:0] ADDR_CLOCK_SELECT_REG = 8'hc0;
    localparam logic [7:0] ADDR_RANDOM = 8'hc4;
    localparam logic [7:0] ADDR_KEY_A = 8'hc8;
    localparam logic [7:0] ADDR_KEY_D = 8'hc9;

    // Registers held inside the checker
    localparam logic [7:0] ADDR_FW_CTRL_LO = 8'ha0;
    localparam logic [7:0] ADDR_FW_CTRL_HI = 8'ha1;
    localparam logic [7:0] ADDR_XBASE_LO = 8'ha2;
    localparam logic [7:0] ADDR_XBASE_HI = 8'ha3;
    localparam logic [7:0] ADDR_XSIZE_LO = 8'ha4;
    localparam logic [7:0] ADDR_XSIZE_HI = 8'ha5;
    localparam logic [7:0] ADDR_VIOL = 8'ha6;
    localparam logic [7:0] RST_FW_REG = 8'h00;

    // Status word bit positions that select the mode
    localparam int STW_CLOS_BIT = 7;
    localparam int STW_SYS_BIT = 6;

    // Hardware register group is cut into 16 slices of 4 addresses
    localparam int HW_SLICE_SHIFT = 2;

    // Memory request from the CPU side, physical address after translation
    typedef struct packed {
        logic valid;
        mbac_op_t op;
        logic copro;
        logic [17:0] addr;
    } mbac_mreq_t;

    // Governing segment entry as delivered by the translation stage
    typedef struct packed {
        logic hit;
        logic rd;
        logic wr;
        logic ex;
        logic [15:0] hw;
    } mbac_seg_t;

endpackage : mbac_pkg

// file: mbac_checker.sv
// Mode based access checker between the CPU core, its memories and registers.
// Assumes translated addresses, segment rights and mode bits arrive on clk_sys.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps

module mbac_checker
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Mode sources
    input wire logic [7:0] upper_status_word,
    input wire logic boot_state,
    input wire logic test_state,
    // Memory request and governing segment
    input wire mbac_pkg::mbac_mreq_t mem_req,
    input wire mbac_pkg::mbac_seg_t seg_entry,
    // Memory side
    output logic mem_grant,
    output logic mem_fwd_valid,
    output logic mem_violation,
    // Register bus from the CPU
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // External register file
    output logic ext_sfr_wr,
    output logic ext_sfr_rd,
    input wire logic [7:0] ext_sfr_rdata,
    // Observed state
    output mbac_pkg::mbac_mode_t cur_mode,
    output logic sfr_violation
);
    import mbac_pkg::*;

    // Inside an inclusive range
    function automatic logic in_rng(input logic [17:0] a, input logic [17:0] lo,
                                    input logic [17:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    // Physical address to region
    function automatic mbac_region_t region_of(input logic [17:0] a);
        region_of = MBAC_RG_NONE;
        if (in_rng(a, ROM_TST_LO, ROM_TST_HI))
            region_of = MBAC_RG_ROM_TST;
        else if (in_rng(a, ROM_ACM_LO, ROM_APP_HI))
            region_of = MBAC_RG_ROM_ACM;
        else if (in_rng(a, ROM_APP_LO, ROM_APP_HI))
            region_of = MBAC_RG_ROM_APP;
        else if (in_rng(a, EE_OS_LO, EE_OS_HI))
            region_of = MBAC_RG_EE_OS;
        else if (in_rng(a, EE_APP_LO, EE_APP_HI))
            region_of = MBAC_RG_EE_APP;
        else if (in_rng(a, RAM_OS_LO, RAM_OS_HI))
            region_of = MBAC_RG_RAM_OS;
        else if (in_rng(a, RAM_APP_LO, RAM_APP_HI))
            region_of = MBAC_RG_RAM_APP;
        else if (in_rng(a, CP_RAM_LO, CP_RAM_HI))
            region_of = MBAC_RG_CP_RAM;
        else if (in_rng(a, SEC_ROW_LO, SEC_ROW_HI))
            region_of = MBAC_RG_SEC_ROW;
    endfunction : region_of

    // Register address to group
    function automatic mbac_group_t group_of(input logic [7:0] a);
        if (a >= GR_HW_LO)
            group_of = MBAC_GR_HW;
        else if (a >= GR_TST_LO)
            group_of = MBAC_GR_TST;
        else if (a >= GR_OS_LO)
            group_of = MBAC_GR_OS;
        else if (a >= GR_FW_LO)
            group_of = MBAC_GR_FW;
        else if (a >= GR_SYSM_LO)
            group_of = MBAC_GR_SYSM;
        else if (a >= GR_SEG_LO)
            group_of = MBAC_GR_SEG;
        else if (a >= GR_CPU_LO)
            group_of = MBAC_GR_CPU;
        else
            group_of = MBAC_GR_NONE;
    endfunction : group_of

    // Firewall and exchange registers, restrictive after reset
    logic [7:0] fw_ctrl_lo;
    logic [7:0] fw_ctrl_hi;
    logic [7:0] xbase_lo;
    logic [7:0] xbase_hi;
    logic [7:0] xsize_lo;
    logic [7:0] xsize_hi;
    logic viol_mem_st;
    logic viol_sfr_st;
    logic [7:0] rdata_q;
    logic mem_viol_q;

    // Mode selection: internal bits first, then the status word
    mbac_mode_t mode;
    assign mode = test_state ? MBAC_TEST :
                  boot_state ? MBAC_BOOT :
                  upper_status_word[STW_CLOS_BIT] ? MBAC_CLOS :
                  upper_status_word[STW_SYS_BIT] ? MBAC_SYS : MBAC_USER;
    assign cur_mode = mode;

    // Memory request decode
    mbac_region_t rg;
    logic op_rd;
    logic op_wr;
    logic op_ex;
    logic rd_ex;
    logic is_rom_app;
    logic is_app;
    logic [15:0] xoff;
    logic [15:0] xbase;
    logic [15:0] xsize;
    logic in_xwin;
    assign rg = region_of(mem_req.addr);
    assign op_rd = mem_req.op == MBAC_OP_READ;
    assign op_wr = mem_req.op == MBAC_OP_WRITE;
    assign op_ex = mem_req.op == MBAC_OP_EXEC;
    assign rd_ex = op_rd || op_ex;
    assign is_rom_app = (rg == MBAC_RG_ROM_APP) || (rg == MBAC_RG_ROM_ACM);
    assign is_app = is_rom_app || (rg == MBAC_RG_EE_APP) || (rg == MBAC_RG_RAM_APP);
    assign xoff = 16'(mem_req.addr - RAM_APP_LO);
    assign xbase = {xbase_hi, xbase_lo};
    assign xsize = {xsize_hi, xsize_lo};
    // Offset compare avoids wrap when base plus size overflows
    assign in_xwin = (rg == MBAC_RG_RAM_APP) && (xoff >= xbase)
                     && ((xoff - xbase) < xsize);

    // Per mode memory rights; RAM is data only, ROM is never written
    logic ok_rom;
    logic ok_ee;
    logic ok_ram;
    logic ok_boot;
    logic ok_test;
    logic ok_clos;
    logic ok_sys;
    logic ok_user;
    logic ok_copro;
    assign ok_rom = rd_ex;
    assign ok_ee = 1'b1;
    assign ok_ram = !op_ex;
    assign ok_boot = ((rg == MBAC_RG_ROM_TST) && ok_rom)
                     || (rg == MBAC_RG_EE_OS)
                     || ((rg == MBAC_RG_RAM_OS) && ok_ram)
                     || ((rg == MBAC_RG_SEC_ROW) && op_rd);
    assign ok_test = ((rg == MBAC_RG_ROM_TST || is_rom_app) && ok_rom)
                     || ((rg == MBAC_RG_EE_OS || rg == MBAC_RG_EE_APP) && ok_ee)
                     || ((rg == MBAC_RG_RAM_OS || rg == MBAC_RG_RAM_APP) && ok_ram);
    assign ok_clos = ((rg == MBAC_RG_ROM_TST) && ok_rom)
                     || (rg == MBAC_RG_EE_OS)
                     || ((rg == MBAC_RG_RAM_OS) && ok_ram)
                     || ((rg == MBAC_RG_ROM_ACM) && op_rd)
                     || (in_xwin && ok_ram)
                     || ((rg == MBAC_RG_SEC_ROW) && op_rd);
    assign ok_sys = (is_rom_app && ok_rom)
                    || (rg == MBAC_RG_EE_APP)
                    || ((rg == MBAC_RG_RAM_APP) && ok_ram);
    assign ok_user = is_app && seg_entry.hit
                     && ((op_rd && seg_entry.rd) || (op_wr && seg_entry.wr)
                         || (op_ex && seg_entry.ex))
                     && !(is_rom_app && op_wr)
                     && !((rg == MBAC_RG_RAM_APP) && op_ex);
    assign ok_copro = ((rg == MBAC_RG_EE_OS || rg == MBAC_RG_EE_APP) && op_rd)
                      || ((rg == MBAC_RG_CP_RAM) && !op_ex);

    // Memory decision for the requester and mode in force
    logic mem_ok;
    always_comb
    begin
        mem_ok = 1'b0;
        if (mem_req.copro)
            mem_ok = ok_copro;
        else
        begin
            unique case (mode)
                MBAC_BOOT: mem_ok = ok_boot;
                MBAC_TEST: mem_ok = ok_test;
                MBAC_CLOS: mem_ok = ok_clos;
                MBAC_SYS: mem_ok = ok_sys;
                MBAC_USER: mem_ok = ok_user;
                default: mem_ok = 1'b0;
            endcase
        end
    end

    // Only checked requests go on to the array
    assign mem_grant = mem_req.valid && mem_ok;
    assign mem_fwd_valid = mem_grant;

    // Register access decode
    mbac_group_t grp;
    logic [15:0] fw_ctrl;
    logic [3:0] hw_slice;
    logic hw_fw_ok;
    logic hw_seg_ok;
    logic is_local;
    logic deny_rd;
    logic deny_wr;
    logic sfr_rd_ok;
    logic sfr_wr_ok;
    assign grp = group_of(sfr_addr);
    assign fw_ctrl = {fw_ctrl_hi, fw_ctrl_lo};
    assign hw_slice = 4'((sfr_addr - GR_HW_LO) >> HW_SLICE_SHIFT);
    assign hw_fw_ok = fw_ctrl[hw_slice];
    assign hw_seg_ok = seg_entry.hw[hw_slice];
    assign is_local = (sfr_addr >= ADDR_FW_CTRL_LO) && (sfr_addr <= ADDR_VIOL);
    // Fixed refusals hold in every mode, boot and test included
    assign deny_rd = (sfr_addr == ADDR_SYSPTR0) || (sfr_addr == ADDR_SYSPTR1)
                     || (sfr_addr == ADDR_KEY_A) || (sfr_addr == ADDR_KEY_D);
    assign deny_wr = sfr_addr == ADDR_RANDOM;

    // Group rights per mode; the write flag selects read or write rights
    function automatic logic grp_ok(input mbac_mode_t m, input mbac_group_t g,
                                    input logic wr, input logic [7:0] a,
                                    input logic fw_ok, input logic seg_ok);
        logic full;
        full = (m == MBAC_BOOT) || (m == MBAC_TEST);
        grp_ok = 1'b0;
        unique case (g)
            MBAC_GR_CPU: grp_ok = 1'b1;
            MBAC_GR_SEG: grp_ok = m == MBAC_SYS;
            MBAC_GR_SYSM: grp_ok = full || (m == MBAC_SYS)
                                   || (!wr && (a == ADDR_STATUS_HI)
                                       && (m == MBAC_CLOS || m == MBAC_USER));
            MBAC_GR_FW: grp_ok = full || (m == MBAC_SYS) || (!wr && m == MBAC_CLOS);
            MBAC_GR_OS: grp_ok = full || (m == MBAC_CLOS);
            MBAC_GR_TST: grp_ok = full;
            MBAC_GR_HW: grp_ok = full || (m == MBAC_SYS)
                                 || ((m == MBAC_CLOS) && (fw_ok
                                     || (!wr && a == ADDR_CLOCK_SELECT_REG)))
                                 || ((m == MBAC_USER) && seg_ok);
            MBAC_GR_NONE: grp_ok = 1'b0;
        endcase
    endfunction : grp_ok

    // Read and write decisions against the mode of this very cycle
    logic ok_grp_rd;
    logic ok_grp_wr;
    assign ok_grp_rd = grp_ok(mode, grp, 1'b0, sfr_addr, hw_fw_ok, hw_seg_ok);
    assign ok_grp_wr = grp_ok(mode, grp, 1'b1, sfr_addr, hw_fw_ok, hw_seg_ok);
    assign sfr_rd_ok = sfr_rd && ok_grp_rd && !deny_rd;
    assign sfr_wr_ok = sfr_wr && ok_grp_wr && !deny_wr;
    assign ext_sfr_rd = sfr_rd_ok && !is_local;
    assign ext_sfr_wr = sfr_wr_ok && !is_local;

    // Local read mux; external data must be valid in the strobe cycle
    logic [7:0] local_rdata;
    logic [7:0] next_rdata;
    always_comb
    begin
        local_rdata = 8'h00;
        unique case (sfr_addr)
            ADDR_FW_CTRL_LO: local_rdata = fw_ctrl_lo;
            ADDR_FW_CTRL_HI: local_rdata = fw_ctrl_hi;
            ADDR_XBASE_LO: local_rdata = xbase_lo;
            ADDR_XBASE_HI: local_rdata = xbase_hi;
            ADDR_XSIZE_LO: local_rdata = xsize_lo;
            ADDR_XSIZE_HI: local_rdata = xsize_hi;
            ADDR_VIOL: local_rdata = {6'h00, viol_sfr_st, viol_mem_st};
            default: local_rdata = 8'h00;
        endcase
    end
    assign next_rdata = !sfr_rd_ok ? 8'h00 : (is_local ? local_rdata : ext_sfr_rdata);

    // Read data register; zero when refused or idle
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rdata_q <= 8'h00;
        else
            rdata_q <= next_rdata;
    end
    assign sfr_rdata = rdata_q;

    // Local register writes, only when granted
    logic lwr;
    assign lwr = sfr_wr_ok && is_local;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            fw_ctrl_lo <= RST_FW_REG;
            fw_ctrl_hi <= RST_FW_REG;
            xbase_lo <= RST_FW_REG;
            xbase_hi <= RST_FW_REG;
            xsize_lo <= RST_FW_REG;
            xsize_hi <= RST_FW_REG;
        end
        else if (lwr)
        begin
            if (sfr_addr == ADDR_FW_CTRL_LO)
                fw_ctrl_lo <= sfr_wdata;
            if (sfr_addr == ADDR_FW_CTRL_HI)
                fw_ctrl_hi <= sfr_wdata;
            if (sfr_addr == ADDR_XBASE_LO)
                xbase_lo <= sfr_wdata;
            if (sfr_addr == ADDR_XBASE_HI)
                xbase_hi <= sfr_wdata;
            if (sfr_addr == ADDR_XSIZE_LO)
                xsize_lo <= sfr_wdata;
            if (sfr_addr == ADDR_XSIZE_HI)
                xsize_hi <= sfr_wdata;
        end
    end

    // Violation events and sticky flags; a new event beats a clear
    logic mem_viol_ev;
    logic sfr_viol_ev;
    logic viol_clr;
    assign mem_viol_ev = mem_req.valid && !mem_ok;
    assign sfr_viol_ev = (sfr_rd && !sfr_rd_ok) || (sfr_wr && !sfr_wr_ok);
    assign viol_clr = lwr && (sfr_addr == ADDR_VIOL);
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            viol_mem_st <= 1'b0;
            viol_sfr_st <= 1'b0;
            mem_viol_q <= 1'b0;
        end
        else
        begin
            viol_mem_st <= mem_viol_ev || (viol_mem_st && !(viol_clr && sfr_wdata[0]));
            viol_sfr_st <= sfr_viol_ev || (viol_sfr_st && !(viol_clr && sfr_wdata[1]));
            mem_viol_q <= mem_viol_ev;
        end
    end
    assign mem_violation = mem_viol_q;
    assign sfr_violation = viol_sfr_st;

endmodule : mbac_checker

// file: mbac_monitor.sv
// Port checker for the mode based access checker.
// Assumes the single clk_sys domain with synchronous reset sys_rst.
`timescale 1ns/10ps
module mbac_monitor
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Mode and memory side
    input wire logic test_state,
    input wire mbac_pkg::mbac_mreq_t mem_req,
    input wire logic mem_grant,
    input wire logic mem_fwd_valid,
    input wire logic mem_violation,
    input wire mbac_pkg::mbac_mode_t cur_mode,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic ext_sfr_wr,
    input wire logic ext_sfr_rd
);
    import mbac_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Address decodes, kept apart from the design's own
    wire seg_grp = (sfr_addr[7:3] == 5'h12);
    wire key_reg = (sfr_addr == ADDR_KEY_A) || (sfr_addr == ADDR_KEY_D);
    wire ptr_reg = (sfr_addr == ADDR_SYSPTR0) || (sfr_addr == ADDR_SYSPTR1);
    property p_fwd; mem_fwd_valid == mem_grant; endproperty
    a_fwd: assert property (p_fwd) else $error("forward differs from grant");
    property p_viol; mem_req.valid && !mem_grant |=> mem_violation; endproperty
    a_viol: assert property (p_viol) else $error("refusal not flagged");
    property p_quiet; mem_req.valid && mem_grant |=> !mem_violation; endproperty
    a_quiet: assert property (p_quiet) else $error("grant flagged");
    property p_idle; !mem_req.valid |-> !mem_grant; endproperty
    a_idle: assert property (p_idle) else $error("grant without request");
    property p_low; sfr_rd && sfr_addr < 8'h80 |=> sfr_rdata == 8'h00; endproperty
    a_low: assert property (p_low) else $error("low address read data");
    property p_hold; !sfr_rd |=> sfr_rdata == 8'h00; endproperty
    a_hold: assert property (p_hold) else $error("read data without read");
    property p_key; sfr_rd && key_reg |-> !ext_sfr_rd ##1 sfr_rdata == 8'h00; endproperty
    a_key: assert property (p_key) else $error("key readable");
    property p_ptr; sfr_rd && ptr_reg |-> !ext_sfr_rd ##1 sfr_rdata == 8'h00; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer readable");
    property p_rnd; sfr_wr && sfr_addr == ADDR_RANDOM |-> !ext_sfr_wr; endproperty
    a_rnd: assert property (p_rnd) else $error("random register written");
    property p_seg;
        (sfr_rd || sfr_wr) && seg_grp && cur_mode != MBAC_SYS |-> !(ext_sfr_rd || ext_sfr_wr);
    endproperty
    a_seg: assert property (p_seg) else $error("segment group reached");
    property p_cpu; sfr_rd && sfr_addr[7:4] == 4'h8 |-> ext_sfr_rd; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu register refused");
    property p_mode; test_state |-> cur_mode == MBAC_TEST; endproperty
    a_mode: assert property (p_mode) else $error("test bit not dominant");
    // Main scenarios
    c_viol: cover property (mem_violation);
    c_user: cover property (sfr_rd && cur_mode == MBAC_USER);
    c_ext: cover property (ext_sfr_wr);
endmodule : mbac_monitor

bind mbac_checker mbac_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .test_state(test_state), .mem_req(mem_req), .mem_grant(mem_grant),
    .mem_fwd_valid(mem_fwd_valid), .mem_violation(mem_violation), .cur_mode(cur_mode),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .ext_sfr_wr(ext_sfr_wr), .ext_sfr_rd(ext_sfr_rd));

// file: mbac_regfile_model.sv
// External register file model behind the checker.
// Assumes single cycle granted strobes on clk_sys.
`timescale 1ns/10ps
module mbac_regfile_model
(
    // Clock
    input wire logic clk_sys,
    // Granted strobes and bus
    input wire logic ext_sfr_wr,
    input wire logic ext_sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    // Read data
    output logic [7:0] ext_sfr_rdata
);
    logic [7:0] regs [256];
    logic [7:0] last = 8'h00;
    // Seed pattern the bench can predict
    initial
    begin
        for (int i = 0; i < 256; i++)
            regs[i] = 8'(i) ^ 8'h5a;
    end
    // Only granted writes land
    always @(posedge clk_sys)
    begin
        if (ext_sfr_rd)
            last <= regs[sfr_addr];
        if (ext_sfr_wr)
            regs[sfr_addr] <= sfr_wdata;
    end
    // Outside a read the bus shows a stale inverse, so a leak is visible
    assign ext_sfr_rdata = ext_sfr_rd ? regs[sfr_addr] : ~last;
endmodule : mbac_regfile_model

// file: mbac_checker_test.sv
// Testbench for the mode based access checker.
// Assumes the register file model and the bound port checker.
`timescale 1ns/10ps
module mbac_checker_test;
    import mbac_pkg::*;
    localparam mbac_op_t R = MBAC_OP_READ;
    localparam mbac_op_t W = MBAC_OP_WRITE;
    localparam mbac_op_t X = MBAC_OP_EXEC;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] usw = 8'h00;
    logic boot_state = 1'b0;
    logic test_state = 1'b0;
    mbac_mreq_t mem_req = '0;
    mbac_seg_t seg_entry = '0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic cp = 1'b0;
    logic mem_grant, mem_fwd_valid, mem_violation, ext_sfr_wr, ext_sfr_rd, sfr_violation;
    logic [7:0] sfr_rdata, ext_sfr_rdata;
    mbac_mode_t cur_mode;
    int err_total = 0;
    int checked = 0;
    mbac_checker dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .upper_status_word(usw),
        .boot_state(boot_state), .test_state(test_state), .mem_req(mem_req),
        .seg_entry(seg_entry), .mem_grant(mem_grant), .mem_fwd_valid(mem_fwd_valid),
        .mem_violation(mem_violation), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ext_sfr_wr(ext_sfr_wr),
        .ext_sfr_rd(ext_sfr_rd), .ext_sfr_rdata(ext_sfr_rdata), .cur_mode(cur_mode),
        .sfr_violation(sfr_violation));
    mbac_regfile_model u_regs (.clk_sys(clk_sys), .ext_sfr_wr(ext_sfr_wr),
        .ext_sfr_rd(ext_sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .ext_sfr_rdata(ext_sfr_rdata));
    // 100 MHz clock
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic end_sim;
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Seeded value of an untouched external register
    function automatic logic [7:0] pv(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction : pv
    task automatic mode(input mbac_mode_t m);
        @(posedge clk_sys);
        test_state <= (m == MBAC_TEST);
        boot_state <= (m == MBAC_BOOT);
        usw <= {m == MBAC_CLOS, m == MBAC_SYS, 6'h00};
        @(posedge clk_sys);
        #1 chk("cur_mode", 8'(cur_mode), 8'(m));
    endtask : mode
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1 chk("sfr_rdata", sfr_rdata, e);
    endtask : rd
    task automatic mem(input mbac_op_t op, input logic [17:0] a, input logic g);
        @(posedge clk_sys);
        mem_req <= '{1'b1, op, cp, a};
        #1 chk("mem_grant", 8'(mem_grant), 8'(g));
        chk("mem_fwd_valid", 8'(mem_fwd_valid), 8'(g));
        @(posedge clk_sys);
        mem_req.valid <= 1'b0;
        #1 chk("mem_violation", 8'(mem_violation), 8'(!g));
    endtask : mem
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        end_sim();
    end
    initial
    begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        mode(MBAC_BOOT);
        rd(8'ha0, 8'h00);
        rd(8'h40, 8'h00);
        rd(8'hb0, pv(8'hb0));
        rd(8'h90, 8'h00);
        chk("sfr_violation", 8'(sfr_violation), 8'h01);
        rd(8'hc8, 8'h00);
        rd(8'h9a, 8'h00);
        wr(8'hc4, 8'h11);
        rd(8'hc4, pv(8'hc4));
        mem(X, ROM_TST_HI, 1'b1);
        mem(R, ROM_APP_LO, 1'b0);
        mem(W, EE_OS_HI, 1'b1);
        mem(X, RAM_OS_LO, 1'b0);
        mem(R, SEC_ROW_LO, 1'b1);
        mode(MBAC_TEST);
        rd(8'ha8, pv(8'ha8));
        mem(R, ROM_APP_HI, 1'b1);
        mem(W, ROM_TST_LO, 1'b0);
        mem(W, EE_APP_HI, 1'b1);
        mem(X, RAM_APP_HI, 1'b0);
        mode(MBAC_SYS);
        wr(8'ha6, 8'h03);
        #1 chk("sfr_violation", 8'(sfr_violation), 8'h00);
        wr(8'h91, 8'h33);
        rd(8'h91, 8'h33);
        rd(8'ha8, 8'h00);
        wr(8'ha0, 8'h02);
        wr(8'ha2, 8'h10);
        wr(8'ha4, 8'h04);
        mem(X, ROM_APP_LO, 1'b1);
        mem(R, ROM_TST_HI, 1'b0);
        mem(W, EE_OS_HI, 1'b0);
        mem(W, RAM_APP_HI, 1'b1);
        mode(MBAC_CLOS);
        rd(8'ha6, 8'h03);
        rd(8'hc0, pv(8'hc0));
        rd(8'hc1, 8'h00);
        rd(8'hc5, pv(8'hc5));
        wr(8'ha0, 8'hff);
        rd(8'ha0, 8'h02);
        wr(8'ha9, 8'h66);
        rd(8'ha9, 8'h66);
        rd(8'h98, pv(8'h98));
        mem(R, ROM_ACM_LO, 1'b1);
        mem(R, ROM_ACM_LO - 18'h1, 1'b0);
        mem(W, RAM_APP_LO + 18'h10, 1'b1);
        mem(R, RAM_APP_LO + 18'h13, 1'b1);
        mem(R, RAM_APP_LO + 18'h14, 1'b0);
        mem(R, RAM_APP_LO + 18'h0f, 1'b0);
        mem(X, ROM_TST_LO, 1'b1);
        mem(R, EE_APP_LO, 1'b0);
        mem(R, SEC_ROW_HI, 1'b1);
        @(posedge clk_sys);
        seg_entry <= '{1'b1, 1'b1, 1'b0, 1'b0, 16'h0004};
        mode(MBAC_USER);
        rd(8'hca, pv(8'hca));
        rd(8'hc0, 8'h00);
        rd(8'h98, pv(8'h98));
        rd(8'h85, pv(8'h85));
        mem(R, EE_APP_LO, 1'b1);
        mem(W, EE_APP_LO, 1'b0);
        mem(R, EE_OS_LO, 1'b0);
        mem(R, CP_RAM_LO, 1'b0);
        cp = 1'b1;
        mem(R, EE_OS_LO, 1'b1);
        mem(W, CP_RAM_HI, 1'b1);
        end_sim();
    end
endmodule : mbac_checker_test
